// ===== rtl/spi_ctrl_pkg.sv
// Constants and types shared by the serial peripheral control block
package spi_ctrl_pkg;
    // Register word addresses on the plain register port
    localparam logic [1:0] ADDR_CONTROL = 2'h0;
    localparam logic [1:0] ADDR_STATUS = 2'h1;
    localparam logic [1:0] ADDR_DATA = 2'h2;
    localparam logic [1:0] ADDR_MASK = 2'h3;
    // Control field positions
    localparam int CTL_IRQ_EN = 7;
    localparam int CTL_ENABLE = 6;
    localparam int CTL_RATE_HIGH = 5;
    localparam int CTL_ROLE = 4;
    localparam int CTL_IDLE = 3;
    localparam int CTL_PHASE = 2;
    // Status field positions
    localparam int ST_DONE = 7;
    localparam int ST_COLL = 6;
    localparam int ST_FAULT = 4;
    // Reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    // Master half-period is 2 << rate code reference cycles
    localparam logic [7:0] HALF_BASE = 8'h02;
    localparam logic [2:0] BIT_LAST = 3'h7;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LEAD = 2'b01,
        ST_TRAIL = 2'b11
    } xfer_state_t;
endpackage

// ===== rtl/serial_peripheral_ctrl_status.sv
// Serial peripheral: control/status registers, master clock generator and shifter
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/10ps

// How it works
// - Control bit 4 picks role: 0 slave, 1 master, software writable
// - In master role a low slave select clears role and sets mode fault
// - Master drives serial clock; data pin directions swap against slave role
// - Control bit 3 sets clock idle level: 0 low, 1 high
// - Idle level setting applies the same in master and slave role
// - Control bit 2: 0 capture on first edge, 1 on second edge
// - Control bits 1:0 with the high rate bit pick master clock rate
// - Low rate bits have no effect in slave role
module serial_peripheral_ctrl_status (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic sclk_in,
    output logic sclk_out,
    output logic sclk_oe,
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe,
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe,
    input wire logic ss_n,
    output logic irq
);
    typedef spi_ctrl_pkg::xfer_state_t xfer_state_t_w;

    typedef struct packed {
        logic [7:0] control;
        logic [7:0] status;
        logic [7:0] mask;
        logic [7:0] shifter;
        logic [7:0] rx_data;
        logic [7:0] rdata;
        logic [2:0] bit_cnt;
        logic [7:0] div_cnt;
        xfer_state_t_w state;
        logic sampled;
        logic status_seen;
        logic [2:0] sclk_sync;
        logic [2:0] ss_sync;
        logic [2:0] mosi_sync;
        logic [2:0] miso_sync;
        logic sclk_prev;
        logic sclk_pin;
        logic irq;
        logic sclk_drive;
        logic miso_drive;
        logic [2:0] cap_dly;
        logic [2:0] end_dly;
    } state_t;

    state_t cur;
    state_t nxt;

    function automatic logic [7:0] half_period(input logic [2:0] code);
        logic [8:0] wide;
        // Reload one short: divider counts down to zero, so the slowest code still fits
        wide = {1'b0, spi_ctrl_pkg::HALF_BASE} << code;
        half_period = 8'(wide - 9'h001);
    endfunction

    logic master;
    logic enabled;
    logic idle_lvl;
    logic phase;
    logic ss_low;
    logic slave_sel;
    logic sclk_s;
    logic sclk_rise;
    logic sclk_fall;
    logic lead_edge;
    logic trail_edge;
    logic in_bit;
    logic tick;
    logic [2:0] rate_code;
    logic data_wr;
    logic data_acc;
    logic byte_done;
    logic busy;

    always_comb
    begin
        master = cur.control[spi_ctrl_pkg::CTL_ROLE];
        enabled = cur.control[spi_ctrl_pkg::CTL_ENABLE];
        idle_lvl = cur.control[spi_ctrl_pkg::CTL_IDLE];
        phase = cur.control[spi_ctrl_pkg::CTL_PHASE];
        // Change counts only when second and third stages agree
        ss_low = (cur.ss_sync[1] == cur.ss_sync[2]) ? ~cur.ss_sync[2] : 1'b0;
        slave_sel = ~cur.ss_sync[2] & ~cur.ss_sync[1];
        sclk_s = (cur.sclk_sync[1] == cur.sclk_sync[2]) ? cur.sclk_sync[2] : cur.sclk_prev;
        sclk_rise = sclk_s & ~cur.sclk_prev;
        sclk_fall = ~sclk_s & cur.sclk_prev;
        // Leading edge leaves idle level, whichever role
        lead_edge = idle_lvl ? sclk_fall : sclk_rise;
        trail_edge = idle_lvl ? sclk_rise : sclk_fall;
        in_bit = master ? cur.miso_sync[2] : cur.mosi_sync[2];
        rate_code = {cur.control[spi_ctrl_pkg::CTL_RATE_HIGH], cur.control[1:0]};
        tick = (cur.div_cnt == 8'h00);
        busy = cur.state != spi_ctrl_pkg::ST_IDLE || cur.end_dly != 3'h0;
        data_wr = reg_write && reg_addr == spi_ctrl_pkg::ADDR_DATA;
        data_acc = (reg_write || reg_read) && reg_addr == spi_ctrl_pkg::ADDR_DATA;
        byte_done = 1'b0;

        nxt = cur;
        nxt.sclk_sync = {cur.sclk_sync[1:0], sclk_in};
        nxt.ss_sync = {cur.ss_sync[1:0], ss_n};
        nxt.mosi_sync = {cur.mosi_sync[1:0], mosi_in};
        nxt.miso_sync = {cur.miso_sync[1:0], miso_in};
        nxt.sclk_prev = sclk_s;
        nxt.cap_dly = {cur.cap_dly[1:0], 1'b0};
        nxt.end_dly = {cur.end_dly[1:0], 1'b0};
        // Master samples three cycles late to match the input synchroniser
        if (cur.cap_dly[2])
            nxt.rx_data = {cur.rx_data[6:0], cur.miso_sync[2]};
        // Done waits for the last late sample
        if (cur.end_dly[2])
            byte_done = 1'b1;

        // Transfer engine
        if (!enabled)
        begin
            nxt.state = spi_ctrl_pkg::ST_IDLE;
            nxt.sclk_pin = idle_lvl;
        end
        else if (master)
        begin
            // Low rate bits only feed the master divider
            if (cur.state != spi_ctrl_pkg::ST_IDLE)
            begin
                nxt.div_cnt = tick ? half_period(rate_code) : cur.div_cnt - 8'h01;
                if (tick)
                begin
                    nxt.sclk_pin = ~cur.sclk_pin;
                    if (cur.state == spi_ctrl_pkg::ST_LEAD)
                    begin
                        nxt.state = spi_ctrl_pkg::ST_TRAIL;
                        if (!phase)
                            nxt.cap_dly[0] = 1'b1;
                        else if (cur.bit_cnt != 3'h0)
                            nxt.shifter = {cur.shifter[6:0], 1'b0}; // First bit already on the pin
                    end
                    else
                    begin
                        if (phase)
                            nxt.cap_dly[0] = 1'b1;
                        else
                            nxt.shifter = {cur.shifter[6:0], 1'b0};
                        nxt.bit_cnt = cur.bit_cnt + 3'h1;
                        if (cur.bit_cnt == spi_ctrl_pkg::BIT_LAST)
                        begin
                            nxt.state = spi_ctrl_pkg::ST_IDLE;
                            nxt.end_dly[0] = 1'b1;
                        end
                        else
                            nxt.state = spi_ctrl_pkg::ST_LEAD;
                    end
                end
            end
            else
                nxt.sclk_pin = idle_lvl;
        end
        else if (slave_sel)
        begin
            if (lead_edge)
            begin
                if (!phase)
                    nxt.rx_data = {cur.rx_data[6:0], in_bit};
                else if (cur.sampled)
                    nxt.shifter = {cur.shifter[6:0], 1'b0};
                nxt.sampled = 1'b1;
                nxt.state = spi_ctrl_pkg::ST_TRAIL;
            end
            if (trail_edge)
            begin
                if (phase)
                    nxt.rx_data = {cur.rx_data[6:0], in_bit};
                else
                    nxt.shifter = {cur.shifter[6:0], 1'b0};
                nxt.bit_cnt = cur.bit_cnt + 3'h1;
                nxt.state = spi_ctrl_pkg::ST_LEAD;
                if (cur.bit_cnt == spi_ctrl_pkg::BIT_LAST)
                begin
                    nxt.state = spi_ctrl_pkg::ST_IDLE;
                    nxt.sampled = 1'b0;
                    byte_done = 1'b1;
                end
            end
        end
        else
        begin
            // Deselect aborts any partial byte
            nxt.state = spi_ctrl_pkg::ST_IDLE;
            nxt.bit_cnt = 3'h0;
            nxt.sampled = 1'b0;
        end

        // Mode fault: losing the bus while master
        if (master && ss_low)
        begin
            nxt.control[spi_ctrl_pkg::CTL_ROLE] = 1'b0;
            nxt.status[spi_ctrl_pkg::ST_FAULT] = 1'b1;
            nxt.state = spi_ctrl_pkg::ST_IDLE;
            nxt.sclk_pin = idle_lvl;
        end

        // Register writes
        if (reg_write)
        begin
            unique case (reg_addr)
                spi_ctrl_pkg::ADDR_CONTROL:
                begin
                    nxt.control = reg_wdata;
                    if (master && ss_low)
                        nxt.control[spi_ctrl_pkg::CTL_ROLE] = 1'b0;
                end
                spi_ctrl_pkg::ADDR_MASK: nxt.mask = reg_wdata;
                spi_ctrl_pkg::ADDR_DATA:
                begin
                    if (cur.status[spi_ctrl_pkg::ST_DONE] && !cur.status_seen)
                        nxt.shifter = cur.shifter; // Inhibited until status read
                    else if (busy || (!master && cur.sampled))
                        nxt.status[spi_ctrl_pkg::ST_COLL] = 1'b1;
                    else
                    begin
                        nxt.shifter = reg_wdata;
                        nxt.bit_cnt = 3'h0;
                        if (master && enabled)
                        begin
                            nxt.state = spi_ctrl_pkg::ST_LEAD;
                            nxt.div_cnt = half_period(rate_code);
                        end
                    end
                end
                default: ;
            endcase
        end

        // Register reads; status read clears the sticky error bits
        nxt.rdata = 8'h00;
        if (reg_read)
        begin
            unique case (reg_addr)
                spi_ctrl_pkg::ADDR_CONTROL: nxt.rdata = cur.control;
                spi_ctrl_pkg::ADDR_STATUS:
                begin
                    nxt.rdata = cur.status;
                    nxt.status_seen = cur.status[spi_ctrl_pkg::ST_DONE];
                    nxt.status[spi_ctrl_pkg::ST_FAULT] = 1'b0;
                    nxt.status[spi_ctrl_pkg::ST_COLL] = 1'b0;
                end
                spi_ctrl_pkg::ADDR_DATA: nxt.rdata = cur.rx_data;
                spi_ctrl_pkg::ADDR_MASK: nxt.rdata = cur.mask;
            endcase
        end

        // Two-step clear of done flag
        if (data_acc && cur.status_seen)
        begin
            nxt.status[spi_ctrl_pkg::ST_DONE] = 1'b0;
            nxt.status_seen = 1'b0;
        end
        // New events win over a clear in the same cycle
        if (byte_done)
            nxt.status[spi_ctrl_pkg::ST_DONE] = 1'b1;
        if (master && ss_low)
            nxt.status[spi_ctrl_pkg::ST_FAULT] = 1'b1;
        if (data_wr && busy)
            nxt.status[spi_ctrl_pkg::ST_COLL] = 1'b1;

        nxt.irq = |(nxt.status & nxt.mask) ||
            (nxt.control[spi_ctrl_pkg::CTL_IRQ_EN] && nxt.status[spi_ctrl_pkg::ST_DONE]);

        // Pin directions registered so each enable leaves a flop
        nxt.sclk_drive = nxt.control[spi_ctrl_pkg::CTL_ROLE] & nxt.control[spi_ctrl_pkg::CTL_ENABLE];
        nxt.miso_drive = ~nxt.control[spi_ctrl_pkg::CTL_ROLE] & nxt.control[spi_ctrl_pkg::CTL_ENABLE]
            & ~nxt.ss_sync[2];

        if (rst)
        begin
            nxt = '0;
            nxt.control = spi_ctrl_pkg::CONTROL_RESET;
            nxt.status = spi_ctrl_pkg::STATUS_RESET;
            nxt.mask = spi_ctrl_pkg::MASK_RESET;
            nxt.state = spi_ctrl_pkg::ST_IDLE;
            nxt.ss_sync = 3'h7;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        cur <= nxt;
    end

    // Every output comes straight from the registered state
    always_comb
    begin
        reg_rdata = cur.rdata;
        irq = cur.irq;
        sclk_out = cur.sclk_pin;
        sclk_oe = cur.sclk_drive;
        mosi_out = cur.shifter[7];
        mosi_oe = cur.sclk_drive;
        miso_out = cur.shifter[7];
        miso_oe = cur.miso_drive;
    end
endmodule // serial_peripheral_ctrl_status

// ===== dv/serial_peripheral_ctrl_status_assertions.sv
// Port-level assertions for the serial peripheral control block
`timescale 1ns/10ps
module serial_peripheral_ctrl_status_assertions (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic sclk_out,
    input wire logic sclk_oe,
    input wire logic mosi_oe,
    input wire logic miso_oe,
    input wire logic ss_n,
    input wire logic irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic access;
    assign access = reg_write | reg_read;
    // Synchroniser plus register gives the fault a few cycles to land
    sequence s_fault_seen; sclk_oe && !ss_n; endsequence
    sequence s_role_dropped; ##[1:6] !sclk_oe; endsequence
    property p_rdata_idle; !$past(reg_read) |-> reg_rdata == 8'h00; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its answer cycle");
    property p_mode_fault; s_fault_seen |-> s_role_dropped; endproperty
    a_mode_fault: assert property (p_mode_fault) else $error("master kept role with select low");
    property p_master_dirs; sclk_oe |-> mosi_oe && !miso_oe; endproperty
    a_master_dirs: assert property (p_master_dirs) else $error("master pin directions wrong");
    property p_slave_dirs; miso_oe |-> !sclk_oe && !mosi_oe; endproperty
    a_slave_dirs: assert property (p_slave_dirs) else $error("slave pin directions wrong");
    property p_half_period; sclk_oe && $changed(sclk_out) |=> !sclk_oe || $stable(sclk_out); endproperty
    a_half_period: assert property (p_half_period) else $error("serial clock half period too short");
    property p_irq_fall; $fell(irq) |-> $past(access) || $past(access, 2); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped without an access");
    property p_miso_release; ss_n [*6] |-> !miso_oe; endproperty
    a_miso_release: assert property (p_miso_release) else $error("slave drives data while deselected");
    property p_role_by_write; $rose(sclk_oe) |-> $past(reg_write) || $past(reg_write, 2); endproperty
    a_role_by_write: assert property (p_role_by_write) else $error("clock drive began without a write");
endmodule // serial_peripheral_ctrl_status_assertions

bind serial_peripheral_ctrl_status serial_peripheral_ctrl_status_assertions i_serial_peripheral_ctrl_status_assertions (
    .ref_clk(ref_clk), .rst(rst), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .sclk_out(sclk_out), .sclk_oe(sclk_oe), .mosi_oe(mosi_oe), .miso_oe(miso_oe), .ss_n(ss_n), .irq(irq));

// ===== dv/spi_link_slave_model.sv
// Behavioural far-side slave for master transfers of the block
`timescale 1ns/10ps
module spi_link_slave_model (
    input wire logic sclk,
    input wire logic mosi,
    input wire logic sel_n,
    input wire logic clock_idle_level,
    input wire logic capture_phase,
    input wire logic [7:0] tx,
    output logic miso,
    output logic [7:0] rx
);
    logic [7:0] sh = 8'h00;
    logic started = 1'b0;
    logic cap;
    // Capture edge follows idle level and phase, as the master's
    assign cap = sclk ^ clock_idle_level ^ capture_phase;
    // Released line shows the inverse so a stale bit never passes
    assign miso = sel_n ? ~sh[7] : sh[7];
    always @(negedge sel_n) {sh, started} <= {tx, 1'b0};
    always @(posedge cap) if (!sel_n) {rx, started} <= {rx[6:0], mosi, 1'b1};
    always @(negedge cap) if (!sel_n && started) sh <= {sh[6:0], sh[7]};
endmodule // spi_link_slave_model

// ===== dv/test_serial_peripheral_ctrl_status.sv
// Register-level tests of the serial peripheral against a far-side slave, plus mode fault and slave role driven by the testbench
`timescale 1ns/10ps
module test_serial_peripheral_ctrl_status;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic tb_sclk = 1'b0;
    logic tb_mosi = 1'b0;
    logic ss_n = 1'b1;
    logic psel_n = 1'b1;
    logic pcpol = 1'b0;
    logic pcpha = 1'b0;
    logic [7:0] reg_rdata, rx, q;
    logic sclk_out, sclk_oe, mosi_out, mosi_oe, miso_out, miso_oe, irq, pmiso, sclk_w, mosi_w, miso_w;
    int errors = 0;
    int samples_checked = 0;
    always #5 ref_clk = ~ref_clk;
    assign sclk_w = sclk_oe ? sclk_out : tb_sclk;
    assign mosi_w = mosi_oe ? mosi_out : tb_mosi;
    assign miso_w = miso_oe ? miso_out : pmiso;
    serial_peripheral_ctrl_status i_serial_peripheral_ctrl_status (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .sclk_in(sclk_w),
        .sclk_out(sclk_out), .sclk_oe(sclk_oe), .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
        .miso_in(miso_w), .miso_out(miso_out), .miso_oe(miso_oe), .ss_n(ss_n), .irq(irq));
    spi_link_slave_model i_spi_link_slave_model (.sclk(sclk_w), .mosi(mosi_w), .sel_n(psel_n), .clock_idle_level(pcpol),
        .capture_phase(pcpha), .tx(8'h3c), .miso(pmiso), .rx(rx));
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // Addresses: control 0, status 1, data 2, mask 3
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        {reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
        @(posedge ref_clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        {reg_addr, reg_read} <= {a, 1'b1};
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic wait_irq();
        for (int i = 0; i < 400 && irq !== 1'b1; i++)
            @(posedge ref_clk);
        chk({7'h00, irq}, 8'h01);
    endtask
    task automatic half_period(input logic [7:0] exp);
        logic v;
        logic [7:0] n;
        v = sclk_out;
        n = 8'h00;
        for (int i = 0; i < 100 && sclk_out === v; i++)
            @(posedge ref_clk);
        v = sclk_out;
        while (sclk_out === v && n < 8'h64)
        begin
            @(posedge ref_clk);
            n++;
        end
        chk(n, exp);
    endtask
    // Link clock of 80 ns; reply sampled late, just before each falling edge
    task automatic slave_byte(input logic [7:0] d, output logic [7:0] got);
        for (int i = 7; i >= 0; i--)
        begin
            @(posedge ref_clk);
            {tb_mosi, tb_sclk} <= {d[i], 1'b0};
            repeat (4) @(posedge ref_clk);
            tb_sclk <= 1'b1;
            repeat (3) @(posedge ref_clk);
            got = {got[6:0], miso_w};
        end
        @(posedge ref_clk);
        tb_sclk <= 1'b0;
    endtask
    initial
    begin
        #200000;
        errors++;
        tally_and_finish();
    end
    initial
    begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        rd(2'h0, 8'h00);
        rd(2'h1, 8'h00);
        wr(2'h0, 8'h50);
        rd(2'h0, 8'h50);
        chk({4'h0, sclk_out, sclk_oe, mosi_oe, miso_oe}, 8'h06);
        psel_n = 1'b0;
        wr(2'h0, 8'hd0);
        wr(2'h2, 8'ha5);
        wr(2'h2, 8'h77);
        wait_irq();
        rd(2'h1, 8'hc0);
        chk(rx, 8'ha5);
        rd(2'h2, 8'h3c);
        @(posedge ref_clk);
        #1 chk({7'h00, irq}, 8'h00);
        wr(2'h2, 8'h0f);
        wait_irq();
        wr(2'h2, 8'hf0);
        repeat (60) @(posedge ref_clk);
        rd(2'h1, 8'h80);
        chk(rx, 8'h0f);
        rd(2'h2, 8'h3c);
        psel_n = 1'b1;
        wr(2'h0, 8'h00);
        pcpol = 1'b1;
        wr(2'h0, 8'hd9);
        rd(2'h0, 8'hd9);
        chk({7'h00, sclk_out}, 8'h01);
        psel_n = 1'b0;
        wr(2'h2, 8'h96);
        half_period(8'h04);
        wait_irq();
        rd(2'h1, 8'h80);
        chk(rx, 8'h96);
        rd(2'h2, 8'h3c);
        psel_n = 1'b1;
        wr(2'h0, 8'h00);
        pcpol = 1'b0;
        pcpha = 1'b1;
        wr(2'h0, 8'hd4);
        psel_n = 1'b0;
        wr(2'h2, 8'h69);
        wait_irq();
        rd(2'h1, 8'h80);
        chk(rx, 8'h69);
        rd(2'h2, 8'h3c);
        psel_n = 1'b1;
        wr(2'h0, 8'h00);
        pcpha = 1'b0;
        wr(2'h3, 8'h10);
        wr(2'h0, 8'h50);
        ss_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
        ss_n <= 1'b1;
        rd(2'h0, 8'h40);
        chk({7'h00, irq}, 8'h01);
        rd(2'h1, 8'h10);
        @(posedge ref_clk);
        #1 chk({7'h00, irq}, 8'h00);
        wr(2'h0, 8'h43);
        wr(2'h2, 8'hc3);
        ss_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        chk({5'h00, sclk_oe, mosi_oe, miso_oe}, 8'h01);
        slave_byte(8'h5a, q);
        chk(q, 8'hc3);
        repeat (8) @(posedge ref_clk);
        ss_n <= 1'b1;
        rd(2'h1, 8'h80);
        rd(2'h2, 8'h5a);
        tally_and_finish();
    end
endmodule // test_serial_peripheral_ctrl_status
